// *** dv/gad_switch_model.sv ***
/* antenna switch and pad load model in front of the block.
   assumes selects and pad drives come from the block on the core clock. */
`timescale 1ns/1ns
module gad_switch_model (
    input wire logic clk_i,
    input wire gad_pkg::gad_ant_t ant_i,
    input wire logic [2:0] pin_i,
    input wire logic [2:0] oe_i,
    input wire logic [7:0] lvl1_i,
    input wire logic [7:0] lvl2_i,
    output logic [7:0] strength_o,
    output logic [2:0] pad_o
);
    import gad_pkg::*;
    logic [2:0] last_r = 3'h0;
    // released pads float opposite to their last drive, so a stale level never passes
    always @(posedge clk_i) last_r <= (oe_i & pin_i) | (~oe_i & last_r);
    assign pad_o = (oe_i & pin_i) | (~oe_i & ~last_r);
    // sender keeps a long preamble; each path has its own level
    assign strength_o = ant_i.a2 ? lvl2_i : lvl1_i;
endmodule

// *** dv/gad_top_tb_top.sv ***
/* self-checking bench: register bus, pin mux, antenna diversity, clear channel.
   assumes the switch model feeds strength and pad levels back. */
`timescale 1ns/1ns
module gad_top_tb_top;
    import gad_pkg::*;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic sd = 0, rx = 0, tx = 0, pre = 0, por = 1, mclk = 1;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd;
    logic [7:0] str, lvl1 = 8'h14, lvl2 = 8'h28;
    logic awr, wr, bv, arr, rv, antp, irq;
    logic [1:0] br, rr;
    logic [2:0] pin_o, oe, pup, pad;
    logic [5:0] drv;
    gad_ant_t ant;
    int fail_count = 0, n_compared = 0, cyc = 0;
    gad_top dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
        .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(br),
        .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rready), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .SHUTDOWN_I(sd),
        .RX_ACTIVE_I(rx), .TX_ACTIVE_I(tx), .PREAMBLE_EVAL_I(pre), .SIG_STRENGTH_I(str),
        .POR_I(por), .MCU_CLK_I(mclk), .PIN_I(pad), .PIN_O(pin_o), .PIN_OE_O(oe),
        .PIN_DRIVE_STRENGTH_O(drv), .PIN_PULLUP_ENABLE_O(pup), .ANT_SEL_O(ant),
        .ANT_PIN_O(antp), .IRQ_O(irq));
    gad_switch_model sw (.clk_i(clk), .ant_i(ant), .pin_i(pin_o), .oe_i(oe), .lvl1_i(lvl1),
        .lvl2_i(lvl2), .strength_o(str), .pad_o(pad));
    initial forever #25 clk = ~clk;
    // whole run needs about 1600 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic axw(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        {awv, wv, bready} <= 3'b111;
        awa <= {2'b00, i, 2'b00};
        wd <= {24'h000000, d};
        // valids read back their old value until the next edge
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while ((awv && !awr) || (wv && !wr));
        while (!bv) @(posedge clk);
        bready <= 1'b0;
        chk("bresp", br, RESP_OKAY);
    endtask
    task automatic axr(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er);
        @(posedge clk);
        {arv, rready} <= 2'b11;
        ara <= {2'b00, i, 2'b00};
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rready <= 1'b0;
        chk("rresp", rr, er);
        if (er == RESP_OKAY) chk("rdata", rd, {24'h000000, e});
    endtask
    task automatic t_reset();
        logic [7:0] idx [7] = '{IDX_FUNC_CTRL2, IDX_PIN0_CFG, IDX_PIN1_CFG, IDX_PIN2_CFG,
            IDX_IO_PORT_CFG, IDX_CCA_THRESH, IDX_IRQ_MASK};
        foreach (idx[k]) axr(idx[k], REG_RESET, RESP_OKAY);
        chk("oe", oe, 3'h7);
        chk("defaults", pin_o, 3'b101);
        por <= 1'b0;
        wt(4);
        chk("por pins", pin_o[1:0], 2'b10);
        axr(IDX_STRENGTH, lvl1, RESP_OKAY);
        axr(8'h3F, 8'h00, RESP_SLVERR);
    endtask
    task automatic t_pins();
        axw(IDX_PIN0_CFG, {2'b11, 1'b1, FN_CCA});
        axw(IDX_PIN1_CFG, {2'b01, 1'b0, FN_ANT1});
        axw(IDX_PIN2_CFG, {2'b10, 1'b0, FN_DIRECT_OUT});
        axw(IDX_IO_PORT_CFG, 8'h04);
        wt(3);
        chk("drive", drv, 6'b100111);
        chk("pullup", pup, 3'b001);
        chk("direct out", pin_o[2], 1'b1);
        axw(IDX_IO_PORT_CFG, 8'h00);
        axw(IDX_PIN2_CFG, {2'b10, 1'b0, FN_DIRECT_IN}); // digital input, never converter
        wt(4);
        axr(IDX_IO_PORT_CFG, 8'h04, RESP_OKAY);
        axr(IDX_PIN0_CFG, 8'hEE, RESP_OKAY);
        sd <= 1'b1;
        wt(3);
        chk("shutdown", pin_o, 3'h0);
        sd <= 1'b0;
    endtask
    task automatic t_manual();
        logic [1:0] act [4] = '{2'b00, 2'b10, 2'b01, 2'b10};
        logic [1:0] idl [4] = '{2'b00, 2'b00, 2'b11, 2'b11};
        axw(IDX_PIN2_CFG, {2'b10, 1'b0, FN_ANT2});
        for (int c = 0; c < 4; c++) begin
            axw(IDX_FUNC_CTRL2, {3'(c), 5'h00});
            wt(3);
            chk("idle ant", ant, idl[c]);
            tx <= 1'b1;
            wt(3);
            chk("active ant", ant, act[c]);
            chk("ant pin", antp, act[c][0]);
            chk("ant1 pin", pin_o[1], act[c][1]);
            chk("ant2 gpio", pin_o[2], act[c][0]);
            tx <= 1'b0;
        end
    endtask
    // n spans the entry into scan plus one dwell swap
    task automatic t_alg(input logic [2:0] code, input int n, input logic [1:0] m,
        input logic [7:0] th, input logic c);
        logic [1:0] prev;
        int k;
        k = 0;
        axw(IDX_FUNC_CTRL2, {code, 5'h00});
        axw(IDX_CCA_THRESH, th); // threshold, not raw polling
        axw(IDX_IRQ_MASK, {6'h00, m});
        rx <= 1'b1;
        prev = ant;
        repeat (n) begin
            @(posedge clk);
            if (ant !== prev) k++;
            prev = ant;
        end
        chk("swaps", k, 2);
        pre <= 1'b1;
        @(posedge clk);
        pre <= 1'b0;
        wt(3);
        chk("lock", ant, 2'b01);
        chk("cca pin", pin_o[0], c);
        chk("irq", irq, |m);
        axr(IDX_IRQ_STATUS, {6'h00, 1'b1, c}, RESP_OKAY);
        wt(400);
        chk("held", ant, 2'b01);
        chk("irq clear", irq, 1'b0);
        rx <= 1'b0;
        wt(3);
        chk("idle", ant, 2'b00);
        tx <= 1'b1;
        wt(3);
        chk("tx ant", ant, 2'b01);
        tx <= 1'b0;
    endtask
    initial begin
        wt(20);
        rst_n <= 1'b1;
        wt(3);
        t_reset();
        t_pins();
        t_manual();
        t_alg(3'b100, 480, 2'b11, 8'h0A, 1'b1);
        t_alg(3'b110, 120, 2'b00, 8'h20, 1'b0);
        report_and_stop();
    end
endmodule

// *** inc/gad_pkg.sv ***
/*
 pin multiplexer, antenna diversity and clear channel check: shared constants and types.
 assumes one 20 MHz core clock and an AXI4-Lite register port with 12-bit byte addresses.
*/
package gad_pkg;
    // clock and diversity dwell timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned DWELL_STD_NS = 16000;
    localparam int unsigned DWELL_BCN_NS = 4000;
    localparam logic [8:0] DWELL_STD_CYC = 9'(DWELL_STD_NS / CLK_PERIOD_NS);
    localparam logic [8:0] DWELL_BCN_CYC = 9'(DWELL_BCN_NS / CLK_PERIOD_NS);
    localparam logic [8:0] DCNT_ZERO = 9'h000;
    localparam logic [8:0] DCNT_STEP = 9'h001;

    // register indices, byte address is index times four
    localparam logic [7:0] IDX_FUNC_CTRL2 = 8'h08;
    localparam logic [7:0] IDX_PIN0_CFG = 8'h0B;
    localparam logic [7:0] IDX_PIN1_CFG = 8'h0C;
    localparam logic [7:0] IDX_PIN2_CFG = 8'h0D;
    localparam logic [7:0] IDX_IO_PORT_CFG = 8'h0E;
    localparam logic [7:0] IDX_STRENGTH = 8'h26;
    localparam logic [7:0] IDX_CCA_THRESH = 8'h27;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
    localparam int ADDR_W = 12;

    // field positions and reset values
    localparam int FC2_DIV_LSB = 5;
    localparam int DIV_ALG_BIT = 2;
    localparam int DIV_BCN_BIT = 1;
    localparam int DIV_IDLE_BIT = 0;
    localparam logic [7:0] IOCFG_RW_MASK = 8'h7F;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [23:0] RDATA_PAD = 24'h000000;

    // antenna diversity control codes
    localparam logic [1:0] DIV_OFF = 2'h0;
    localparam logic [1:0] DIV_A1_LO = 2'h1;
    localparam logic [1:0] DIV_A2_HI = 2'h2;
    localparam logic [1:0] DIV_A1_HI = 2'h3;
    localparam logic [2:0] DIV_BEACON_LO = 3'h6;

    // pin function select codes
    localparam logic [4:0] FN_DEFAULT = 5'h00;
    localparam logic [4:0] FN_DIRECT_IN = 5'h03;
    localparam logic [4:0] FN_ADC_IN = 5'h07;
    localparam logic [4:0] FN_DIRECT_OUT = 5'h0A;
    localparam logic [4:0] FN_CCA = 5'h0E;
    localparam logic [4:0] FN_ANT1 = 5'h17;
    localparam logic [4:0] FN_ANT2 = 5'h18;
    localparam logic [1:0] PIN_IDX0 = 2'h0;
    localparam logic [1:0] PIN_IDX1 = 2'h1;

    // interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_STRENGTH_BIT = 0;
    localparam int IRQ_ANT_LOCK_BIT = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] pin_drive_strength;
        logic pin_pullup_enable;
        logic [4:0] pin_function_select;
    } gad_pin_cfg_t;

    typedef struct packed {
        logic a1;
        logic a2;
    } gad_ant_t;

    typedef enum logic [2:0] {
        DV_IDLE = 3'b001,
        DV_SCAN = 3'b010,
        DV_LOCK = 3'b100
    } gad_dv_e_t;

    typedef struct packed {
        logic [7:0] fc2;
        gad_pin_cfg_t [2:0] cfg;
        logic [7:0] iocfg;
        logic [7:0] thr;
        logic [7:0] rssi;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic cca;
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic por_s1;
        logic por_s2;
        logic mclk_s1;
        logic mclk_s2;
        gad_dv_e_t dv;
        logic [8:0] dcnt;
        logic sel;
        logic [1:0][7:0] meas;
        logic rx_prev;
        logic [2:0] pin_o;
        logic [2:0] pin_oe;
        logic [5:0] drv;
        logic [2:0] pup;
        gad_ant_t ant;
        logic irq;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } gad_state_t;
endpackage

// *** rtl/gad_top.sv ***
/*
 pin multiplexer for three general purpose pins, antenna diversity controller and
 signal strength readout with clear channel comparison, behind an AXI4-Lite slave.
 assumes rx/tx state, shutdown, strength and preamble pulse come from core logic on
 CORE_CLK_I; POR, MCU clock and pad inputs are asynchronous and get synchronised.
*/
`timescale 1ns/1ns
module gad_top (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [gad_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    output logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    input wire logic [gad_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    input wire logic SHUTDOWN_I,
    input wire logic RX_ACTIVE_I,
    input wire logic TX_ACTIVE_I,
    input wire logic PREAMBLE_EVAL_I,
    input wire logic [7:0] SIG_STRENGTH_I,
    input wire logic POR_I,
    input wire logic MCU_CLK_I,
    input wire logic [2:0] PIN_I,
    output logic [2:0] PIN_O,
    output logic [2:0] PIN_OE_O,
    output logic [5:0] PIN_DRIVE_STRENGTH_O,
    output logic [2:0] PIN_PULLUP_ENABLE_O,
    output gad_pkg::gad_ant_t ANT_SEL_O,
    output logic ANT_PIN_O,
    output logic IRQ_O
);
    import gad_pkg::*;

    gad_state_t s;
    gad_state_t n;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        reg_hit = (addr == {2'b00, idx, 2'b00});
    endfunction

    // {output enable, level} for one pin
    function automatic logic [1:0] pin_fn(input logic [4:0] code, input logic [1:0] idx,
                                          input logic por, input logic mclk, input logic dio,
                                          input logic cca, input gad_ant_t ant);
        case (code)
            FN_DEFAULT: begin
                if (idx == PIN_IDX0) begin
                    pin_fn = {1'b1, por};
                end else if (idx == PIN_IDX1) begin
                    pin_fn = {1'b1, !por};
                end else begin
                    pin_fn = {1'b1, mclk};
                end
            end
            FN_DIRECT_IN: pin_fn = 2'h0;
            FN_ADC_IN: pin_fn = 2'h0;
            FN_DIRECT_OUT: pin_fn = {1'b1, dio};
            FN_CCA: pin_fn = {1'b1, cca};
            FN_ANT1: pin_fn = {1'b1, ant.a1};
            FN_ANT2: pin_fn = {1'b1, ant.a2};
            default: pin_fn = 2'h0 | 2'h2;
        endcase
    endfunction

    function automatic logic is_input_fn(input logic [4:0] code);
        is_input_fn = (code == FN_DIRECT_IN) || (code == FN_ADC_IN);
    endfunction

    always_comb begin
        logic [2:0] div;
        logic [8:0] dwell;
        logic act;
        logic rx_rise;
        logic [IRQ_W-1:0] irq_set;
        logic [IRQ_W-1:0] rd_clr;
        logic [1:0] pf;
        logic [2:0] dio_rd;
        logic [7:0] rd;
        logic rd_ok;
        logic wr_ok;
        div = s.fc2[FC2_DIV_LSB +: 3];
        dwell = s.fc2[FC2_DIV_LSB + DIV_BCN_BIT] ? DWELL_BCN_CYC : DWELL_STD_CYC;
        act = RX_ACTIVE_I || TX_ACTIVE_I;
        rx_rise = RX_ACTIVE_I && !s.rx_prev;
        irq_set = '0;
        rd_clr = '0;
        pf = 2'h0;
        dio_rd = 3'h0;
        rd = REG_RESET;
        rd_ok = 1'b0;
        wr_ok = 1'b0;
        n = s;

        // asynchronous inputs: second stage is the only reader of the first
        n.pin_s1 = PIN_I;
        n.pin_s2 = s.pin_s1;
        n.por_s1 = POR_I;
        n.por_s2 = s.por_s1;
        n.mclk_s1 = MCU_CLK_I;
        n.mclk_s2 = s.mclk_s1;
        n.rx_prev = RX_ACTIVE_I;
        n.rssi = SIG_STRENGTH_I;

        // diversity algorithm: scan while preamble unseen, lock on evaluation
        unique case (s.dv)
            DV_IDLE: begin
                if (rx_rise && div[DIV_ALG_BIT]) begin
                    n.dv = DV_SCAN;
                    n.dcnt = dwell;
                    n.meas = '0;
                end
            end
            DV_SCAN: begin
                if (!RX_ACTIVE_I) begin
                    n.dv = DV_IDLE;
                end else if (PREAMBLE_EVAL_I) begin
                    // current antenna uses the live strength, the other its last dwell
                    if (SIG_STRENGTH_I < s.meas[!s.sel]) begin
                        n.sel = !s.sel;
                    end
                    n.dv = DV_LOCK;
                    irq_set[IRQ_ANT_LOCK_BIT] = 1'b1;
                end else if (s.dcnt == DCNT_ZERO) begin
                    n.meas[s.sel] = SIG_STRENGTH_I;
                    n.sel = !s.sel;
                    n.dcnt = dwell;
                end else begin
                    n.dcnt = s.dcnt - DCNT_STEP;
                end
            end
            DV_LOCK: begin
                // sel stays as chosen into the following transmit
                if (!RX_ACTIVE_I) begin
                    n.dv = DV_IDLE;
                end
            end
        endcase

        // clear channel decision once per preamble evaluation
        if (RX_ACTIVE_I && PREAMBLE_EVAL_I && s.dv != DV_LOCK) begin
            n.cca = SIG_STRENGTH_I > s.thr;
            if (SIG_STRENGTH_I > s.thr) begin
                irq_set[IRQ_STRENGTH_BIT] = 1'b1;
            end
        end

        // antenna select levels
        if (div[DIV_ALG_BIT]) begin
            if (act) begin
                n.ant = '{a1: !s.sel, a2: s.sel};
            end else begin
                n.ant = '{a1: div[DIV_IDLE_BIT], a2: div[DIV_IDLE_BIT]};
            end
        end else begin
            unique case (div[1:0])
                DIV_OFF: n.ant = '{a1: 1'b0, a2: 1'b0};
                DIV_A1_LO: n.ant = act ? '{a1: 1'b1, a2: 1'b0} : '{a1: 1'b0, a2: 1'b0};
                DIV_A2_HI: n.ant = act ? '{a1: 1'b0, a2: 1'b1} : '{a1: 1'b1, a2: 1'b1};
                DIV_A1_HI: n.ant = act ? '{a1: 1'b1, a2: 1'b0} : '{a1: 1'b1, a2: 1'b1};
            endcase
        end

        // pin multiplexer; converter input leaves the pad undriven
        for (int i = 0; i < 3; i++) begin
            pf = pin_fn(s.cfg[i].pin_function_select, 2'(i), s.por_s2, s.mclk_s2,
                        s.iocfg[i], s.cca, s.ant);
            n.pin_oe[i] = pf[1];
            n.pin_o[i] = pf[0];
            n.pup[i] = s.cfg[i].pin_pullup_enable;
            n.drv[2*i +: 2] = s.cfg[i].pin_drive_strength;
            dio_rd[i] = is_input_fn(s.cfg[i].pin_function_select) ? s.pin_s2[i] : s.iocfg[i];
        end
        if (SHUTDOWN_I) begin
            n.pin_o = 3'h0;
            n.pin_oe = 3'h7;
            n.pup = 3'h0;
        end

        // register write, taken once address and data are both held
        if (s.aw_got && s.w_got && !s.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            wr_ok = 1'b1;
            if (reg_hit(s.awaddr, IDX_FUNC_CTRL2)) begin
                if (s.wstrb0) n.fc2 = s.wdata;
            end else if (reg_hit(s.awaddr, IDX_PIN0_CFG)) begin
                if (s.wstrb0) n.cfg[0] = s.wdata;
            end else if (reg_hit(s.awaddr, IDX_PIN1_CFG)) begin
                if (s.wstrb0) n.cfg[1] = s.wdata;
            end else if (reg_hit(s.awaddr, IDX_PIN2_CFG)) begin
                if (s.wstrb0) n.cfg[2] = s.wdata;
            end else if (reg_hit(s.awaddr, IDX_IO_PORT_CFG)) begin
                if (s.wstrb0) n.iocfg = s.wdata & IOCFG_RW_MASK;
            end else if (reg_hit(s.awaddr, IDX_CCA_THRESH)) begin
                if (s.wstrb0) n.thr = s.wdata;
            end else if (reg_hit(s.awaddr, IDX_IRQ_MASK)) begin
                if (s.wstrb0) n.irq_mask = s.wdata[IRQ_W-1:0];
            end else if (!reg_hit(s.awaddr, IDX_STRENGTH) &&
                         !reg_hit(s.awaddr, IDX_IRQ_STATUS)) begin
                wr_ok = 1'b0;
            end
            n.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s.bvalid && S_AXI_BREADY_I) begin
            n.bvalid = 1'b0;
        end
        if (S_AXI_AWVALID_I && s.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && s.wready) begin
            n.w_got = 1'b1;
            n.wdata = S_AXI_WDATA_I[7:0];
            n.wstrb0 = S_AXI_WSTRB_I[0];
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        // register read
        rd_ok = 1'b1;
        if (reg_hit(S_AXI_ARADDR_I, IDX_FUNC_CTRL2)) begin
            rd = s.fc2;
        end else if (reg_hit(S_AXI_ARADDR_I, IDX_PIN0_CFG)) begin
            rd = s.cfg[0];
        end else if (reg_hit(S_AXI_ARADDR_I, IDX_PIN1_CFG)) begin
            rd = s.cfg[1];
        end else if (reg_hit(S_AXI_ARADDR_I, IDX_PIN2_CFG)) begin
            rd = s.cfg[2];
        end else if (reg_hit(S_AXI_ARADDR_I, IDX_IO_PORT_CFG)) begin
            rd = {s.iocfg[7:3], dio_rd};
        end else if (reg_hit(S_AXI_ARADDR_I, IDX_STRENGTH)) begin
            rd = s.rssi;
        end else if (reg_hit(S_AXI_ARADDR_I, IDX_CCA_THRESH)) begin
            rd = s.thr;
        end else if (reg_hit(S_AXI_ARADDR_I, IDX_IRQ_STATUS)) begin
            rd = {6'h00, s.irq_st};
        end else if (reg_hit(S_AXI_ARADDR_I, IDX_IRQ_MASK)) begin
            rd = {6'h00, s.irq_mask};
        end else begin
            rd_ok = 1'b0;
        end
        if (S_AXI_ARVALID_I && s.arready) begin
            n.rvalid = 1'b1;
            n.rdata = rd;
            n.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
            if (reg_hit(S_AXI_ARADDR_I, IDX_IRQ_STATUS)) begin
                rd_clr = '1;
            end
        end else if (s.rvalid && S_AXI_RREADY_I) begin
            n.rvalid = 1'b0;
        end
        n.arready = !n.rvalid;

        // a new event beats the read-clear of the same cycle
        n.irq_st = (s.irq_st & ~rd_clr) | irq_set;
        n.irq = |(n.irq_st & s.irq_mask);
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            s <= '0;
            s.dv <= DV_IDLE;
        end else begin
            s <= n;
        end
    end

    assign S_AXI_AWREADY_O = s.awready;
    assign S_AXI_WREADY_O = s.wready;
    assign S_AXI_BVALID_O = s.bvalid;
    assign S_AXI_BRESP_O = s.bresp;
    assign S_AXI_ARREADY_O = s.arready;
    assign S_AXI_RVALID_O = s.rvalid;
    assign S_AXI_RDATA_O = {RDATA_PAD, s.rdata};
    assign S_AXI_RRESP_O = s.rresp;
    assign PIN_O = s.pin_o;
    assign PIN_OE_O = s.pin_oe;
    assign PIN_DRIVE_STRENGTH_O = s.drv;
    assign PIN_PULLUP_ENABLE_O = s.pup;
    assign ANT_SEL_O = s.ant;
    assign ANT_PIN_O = s.ant.a2;
    assign IRQ_O = s.irq;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    property p_shutdown_low;
        SHUTDOWN_I |=> (PIN_O == 3'h0) && (PIN_OE_O == 3'h7) && (PIN_PULLUP_ENABLE_O == 3'h0);
    endproperty
    a_shutdown_low: assert property (p_shutdown_low) else $error("pads not low in shutdown");

    property p_drive_field;
        !SHUTDOWN_I |=> PIN_DRIVE_STRENGTH_O[3:2] == $past(s.cfg[1].pin_drive_strength)
            && PIN_PULLUP_ENABLE_O[1] == $past(s.cfg[1].pin_pullup_enable);
    endproperty
    a_drive_field: assert property (p_drive_field) else $error("pin 1 pad controls wrong");

    property p_default_pin1;
        (RST_N_I && !SHUTDOWN_I && s.cfg[1].pin_function_select == FN_DEFAULT)
            |=> PIN_OE_O[1] && (PIN_O[1] == !$past(s.por_s2));
    endproperty
    a_default_pin1: assert property (p_default_pin1) else $error("pin 1 not inverted por");

    property p_ant_pin;
        (!SHUTDOWN_I && s.cfg[2].pin_function_select == FN_ANT2)
            |=> PIN_O[2] == $past(ANT_PIN_O);
    endproperty
    a_ant_pin: assert property (p_ant_pin) else $error("ant2 pin mismatch");

    logic [8:0] dwell_h;
    assign dwell_h = s.fc2[FC2_DIV_LSB + DIV_BCN_BIT] ? DWELL_BCN_CYC : DWELL_STD_CYC;

    property p_scan_toggle;
        (s.dv == DV_SCAN && RX_ACTIVE_I && !PREAMBLE_EVAL_I && s.dcnt == DCNT_ZERO)
            |=> (s.sel != $past(s.sel)) && (s.dcnt == $past(dwell_h));
    endproperty
    a_scan_toggle: assert property (p_scan_toggle) else $error("scan did not toggle");

    property p_lock_best;
        (s.dv == DV_SCAN && RX_ACTIVE_I && PREAMBLE_EVAL_I && SIG_STRENGTH_I < s.meas[!s.sel])
            |=> (s.sel != $past(s.sel)) && (s.dv == DV_LOCK);
    endproperty
    a_lock_best: assert property (p_lock_best) else $error("weaker antenna kept");

    property p_lock_hold;
        (s.dv == DV_LOCK) |=> $stable(s.sel);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked antenna moved");

    property p_keep_for_tx;
        (s.dv == DV_IDLE && s.fc2[FC2_DIV_LSB + DIV_ALG_BIT] && TX_ACTIVE_I)
            |=> (ANT_SEL_O.a2 == $past(s.sel)) && (ANT_SEL_O.a1 != $past(s.sel));
    endproperty
    a_keep_for_tx: assert property (p_keep_for_tx) else $error("tx antenna not kept");

    property p_off_low;
        (s.fc2[FC2_DIV_LSB +: 3] == 3'h0) |=> (ANT_SEL_O == 2'h0);
    endproperty
    a_off_low: assert property (p_off_low) else $error("antenna select not low");

    property p_manual_idle;
        (s.fc2[FC2_DIV_LSB +: 3] == 3'h3 && !RX_ACTIVE_I && !TX_ACTIVE_I) |=> (ANT_SEL_O == 2'h3);
    endproperty
    a_manual_idle: assert property (p_manual_idle) else $error("idle levels wrong");

    property p_beacon_dwell;
        (s.dv == DV_IDLE && RX_ACTIVE_I && !s.rx_prev && s.fc2[FC2_DIV_LSB +: 3] == DIV_BEACON_LO)
            |=> (s.dv == DV_SCAN) && (s.dcnt == DWELL_BCN_CYC);
    endproperty
    a_beacon_dwell: assert property (p_beacon_dwell) else $error("beacon dwell wrong");

    property p_cca_flag;
        (RX_ACTIVE_I && PREAMBLE_EVAL_I && s.dv != DV_LOCK && SIG_STRENGTH_I > s.thr)
            |=> s.irq_st[IRQ_STRENGTH_BIT] && s.cca;
    endproperty
    a_cca_flag: assert property (p_cca_flag) else $error("strength flag not set");

    property p_cca_pin;
        (!SHUTDOWN_I && s.cfg[0].pin_function_select == FN_CCA) |=> PIN_O[0] == $past(s.cca);
    endproperty
    a_cca_pin: assert property (p_cca_pin) else $error("cca not on pin 0");

    property p_ant_gpio;
        (!SHUTDOWN_I && s.cfg[1].pin_function_select == FN_ANT1) |=> PIN_O[1] == $past(s.ant.a1);
    endproperty
    a_ant_gpio: assert property (p_ant_gpio) else $error("ant1 not on pin 1");

    property p_strength_reg;
        RST_N_I |=> s.rssi == $past(SIG_STRENGTH_I);
    endproperty
    a_strength_reg: assert property (p_strength_reg) else $error("strength not tracked");

    c_lock: cover property (s.dv == DV_SCAN ##1 s.dv == DV_LOCK);
    c_beacon: cover property (s.dv == DV_SCAN && s.fc2[FC2_DIV_LSB + DIV_BCN_BIT]);
    c_irq: cover property ($rose(IRQ_O));
    c_shutdown: cover property (SHUTDOWN_I ##1 !SHUTDOWN_I);
endmodule
